// File: bus_master_model.sv
// two-wire bus master model; clock idles high between frames
`timescale 1ns/100ps
module bus_master_model (
    // clock
    input wire logic mclk,
    // resolved data line
    input wire logic sda_bus,
    // master lines
    output logic scl,
    output logic sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // quarter of a 160 ns bus period, moved on falling mclk only
    task automatic q();
        repeat (5) @(negedge mclk);
    endtask
    task automatic start();
        sda_pull = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_pull = 1'b1;
        q();
        scl = 1'b0;
        q();
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_pull = !b[i];
            q();
            scl = 1'b1;
            q();
            q();
            scl = 1'b0;
            q();
        end
        sda_pull = 1'b0;
        q();
        scl = 1'b1;
        q();
        ack = !sda_bus;
        q();
        scl = 1'b0;
        q();
    endtask
    task automatic stop();
        sda_pull = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_pull = 1'b0;
        q();
    endtask
endmodule // bus_master_model

// File: eeprom_cache_pkg.sv
// shared constants and types for the serial eeprom write cache
package eeprom_cache_pkg;

    // bus framing
    localparam int BYTE_BITS = 8;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] DEV_TYPE_DFLT = 4'ha;
    localparam logic RW_WRITE = 1'b0;
    localparam int CS_W = 3;

    // array and cache geometry
    localparam int ADDR_W = 13;
    localparam int ADDR_HI_W = ADDR_W - BYTE_BITS;
    localparam int CACHE_BYTES = 64;
    localparam int PAGE_BYTES = 8;
    localparam int PAGES = CACHE_BYTES / PAGE_BYTES;
    localparam int PTR_W = $clog2(CACHE_BYTES);
    localparam int POS_W = $clog2(PAGE_BYTES);
    localparam int PG_W = $clog2(PAGES);
    localparam int ROW_W = ADDR_W - POS_W;
    localparam logic [PG_W-1:0] PAGE_LAST = 3'h7;
    localparam logic [POS_W-1:0] POS_LAST = 3'h7;

    // self-timed page programming
    localparam int PAGE_WRITE_MS = 5;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int unsigned PAGE_CYCLES_DFLT = (PAGE_WRITE_MS * 1000000) / (CLK_PERIOD_PS / 1000);
    localparam int TIMER_W = 32;

    // position of a received byte within a command
    typedef enum logic [1:0] {
        IDX_CTRL,
        IDX_ADDR_HI,
        IDX_ADDR_LO,
        IDX_DATA
    } byte_idx_t;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_RX,
        PH_ACK,
        PH_IGNORE,
        PH_PROG,
        PH_WAIT
    } phase_t;

    // synchronised pin levels
    typedef struct packed {
        logic scl;
        logic sda;
        logic [CS_W-1:0] cs;
    } pins_t;

    // array programming port
    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [BYTE_BITS-1:0] data;
    } arr_wr_t;

    // complete state of the cache controller
    typedef struct packed {
        phase_t ph;
        logic scl_q;
        logic sda_q;
        logic [BYTE_BITS-1:0] shreg;
        logic [3:0] bitcnt;
        byte_idx_t idx;
        logic rd;
        logic sda_drive;
        logic [ADDR_W-1:0] base_addr;
        logic [ADDR_W-1:0] addr_ptr;
        logic [PTR_W-1:0] wptr;
        logic [CACHE_BYTES-1:0][BYTE_BITS-1:0] cache;
        logic [CACHE_BYTES-1:0] valid;
        logic [PG_W-1:0] page;
        logic [POS_W-1:0] pos;
        logic [TIMER_W-1:0] timer;
        arr_wr_t arr;
    } ctl_t;

endpackage

// File: eeprom_cache_sva.sv
// port-level assertion checker for the eeprom write cache
`timescale 1ns/100ps
module eeprom_cache_chk
    import eeprom_cache_pkg::*;
#(
    parameter int unsigned PAGE_CYCLES = PAGE_CYCLES_DFLT
)(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // bus
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic [CS_W-1:0] chip_select_pins,
    // array and status
    input wire logic arr_we,
    input wire logic [ADDR_W-1:0] arr_addr,
    input wire logic [BYTE_BITS-1:0] arr_wdata,
    input wire logic busy,
    input wire logic standby
);
    logic sda_q_r;
    logic [3:0] stop_age_r;
    logic [31:0] busy_len_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // raw pins are seen here, so the age bound allows for the design's synchroniser
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sda_q_r <= 1'b1;
            stop_age_r <= 4'hf;
            busy_len_r <= '0;
        end else begin
            sda_q_r <= sda_in;
            if (scl_in && sda_in && !sda_q_r)
                stop_age_r <= 4'h0;
            else if (stop_age_r != 4'hf)
                stop_age_r <= stop_age_r + 4'h1;
            busy_len_r <= busy ? busy_len_r + 32'h1 : 32'h0;
        end
    end
    sda_drain_a: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    busy_quiet_a: assert property (busy |-> sda_oe_n)
        else $error("acknowledge while programming");
    stop_launch_a: assert property ($rose(busy) |-> stop_age_r <= 4'ha)
        else $error("programming began without stop");
    we_in_prog_a: assert property (arr_we |-> busy)
        else $error("array write outside programming");
    addr_step_a: assert property (arr_we && $past(arr_we) |->
        arr_addr == $past(arr_addr) + 13'h1)
        else $error("array address not consecutive");
    page_time_a: assert property ($fell(busy) |-> busy_len_r >= PAGE_CYCLES
        && busy_len_r <= 8 * (PAGE_CYCLES + 16))
        else $error("programming time out of range");
    sda_low_clk_a: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("data changed while clock high");
    ack_stand_a: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*8])
        else $error("acknowledge too short");
    idle_excl_a: assert property (busy |-> !standby)
        else $error("standby while programming");
    prog_start_c: cover property ($rose(busy));
    burst_c: cover property (arr_we && $past(arr_we));
    ack_c: cover property ($fell(sda_oe_n));
endmodule // eeprom_cache_chk

bind serial_eeprom_write_cache eeprom_cache_chk #(.PAGE_CYCLES(PAGE_CYCLES)) chk (
    .mclk(mclk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .chip_select_pins(chip_select_pins), .arr_we(arr_we),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata), .busy(busy), .standby(standby)
);

// File: pin_sync.sv
// two-flop synchroniser for the bus and strap pins
`timescale 1ns/100ps
module pin_sync
    import eeprom_cache_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // asynchronous pins in, clean levels out
    input wire pins_t pins_in,
    output pins_t pins_out
);
    typedef struct packed {
        pins_t meta;
        pins_t stable;
    } sync_t;

    // idle bus is high on both lines
    localparam sync_t SYNC_RST = '{meta: '{scl: 1'b1, sda: 1'b1, cs: '0},
                                   stable: '{scl: 1'b1, sda: 1'b1, cs: '0}};

    sync_t s_r;
    sync_t s_nxt;

    always_comb begin
        s_nxt.meta = pins_in;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= SYNC_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pins_out = s_r.stable;
endmodule // pin_sync

// File: serial_eeprom_write_cache.sv
// two-wire eeprom slave: write cache, page programming and ack polling
`timescale 1ns/100ps
module serial_eeprom_write_cache
    import eeprom_cache_pkg::*;
#(
    parameter int unsigned PAGE_CYCLES = PAGE_CYCLES_DFLT,
    parameter logic [3:0] DEV_TYPE = DEV_TYPE_DFLT  // arbitrary device type code
)(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // strap pins
    input wire logic [CS_W-1:0] chip_select_pins,
    // array programming port
    output logic arr_we,
    output logic [ADDR_W-1:0] arr_addr,
    output logic [BYTE_BITS-1:0] arr_wdata,
    // status
    output logic busy,
    output logic standby
);
    localparam ctl_t CTL_RST = '{ph: PH_IDLE, scl_q: 1'b1, sda_q: 1'b1, idx: IDX_CTRL,
                                 default: '0};

    // array address of a cache slot: page 0 maps to the start page
    function automatic logic [ADDR_W-1:0] arr_of(input logic [ADDR_W-1:0] base,
                                                 input logic [PG_W-1:0] pg,
                                                 input logic [POS_W-1:0] pos);
        logic [ROW_W-1:0] row;
        row = base[ADDR_W-1:POS_W] + ROW_W'(pg);
        return {row, pos};
    endfunction

    function automatic logic page_loaded(input logic [CACHE_BYTES-1:0] v,
                                         input logic [PG_W-1:0] pg);
        return |v[pg*PAGE_BYTES +: PAGE_BYTES];
    endfunction

    logic rst_meta_n;
    logic rst_n;
    pins_t pins_raw;
    pins_t pins;
    ctl_t s_r;
    ctl_t s_nxt;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    assign pins_raw = '{scl: scl_in, sda: sda_in, cs: chip_select_pins};

    pin_sync u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .pins_in(pins_raw),
        .pins_out(pins)
    );

    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        logic [PTR_W-1:0] slot;
        scl_rise = pins.scl & ~s_r.scl_q;
        scl_fall = ~pins.scl & s_r.scl_q;
        start_c = s_r.scl_q & pins.scl & s_r.sda_q & ~pins.sda;
        stop_c = s_r.scl_q & pins.scl & ~s_r.sda_q & pins.sda;
        slot = {s_r.page, s_r.pos};

        s_nxt = s_r;
        s_nxt.scl_q = pins.scl;
        s_nxt.sda_q = pins.sda;
        s_nxt.arr.we = 1'b0;

        case (s_r.ph)
            // self-timed programming: start and stop are not decoded, only the edge history follows the bus
            PH_PROG: begin
                s_nxt.sda_drive = 1'b0;
                if (s_r.valid[slot]) begin
                    s_nxt.arr.we = 1'b1;
                    s_nxt.arr.addr = arr_of(s_r.base_addr, s_r.page, s_r.pos);
                    s_nxt.arr.data = s_r.cache[slot];
                end
                s_nxt.pos = s_r.pos + POS_W'(1);
                if (s_r.pos == POS_LAST) begin
                    s_nxt.ph = PH_WAIT;
                    s_nxt.timer = '0;
                end
            end
            PH_WAIT: begin
                s_nxt.sda_drive = 1'b0;
                s_nxt.timer = s_r.timer + TIMER_W'(1);
                // a partial page still takes the full page time
                if (s_r.timer == TIMER_W'(PAGE_CYCLES - 1)) begin
                    if (s_r.page == PAGE_LAST ||
                        !page_loaded(s_r.valid, s_r.page + PG_W'(1))) begin
                        s_nxt.ph = PH_IDLE;
                        s_nxt.valid = '0;
                    end else begin
                        s_nxt.page = s_r.page + PG_W'(1);
                        s_nxt.pos = '0;
                        s_nxt.ph = PH_PROG;
                    end
                end
            end
            default: begin
                if (start_c) begin
                    // repeated start drops an unfinished cache load
                    s_nxt.ph = PH_RX;
                    s_nxt.bitcnt = '0;
                    s_nxt.idx = IDX_CTRL;
                    s_nxt.rd = 1'b0;
                    s_nxt.sda_drive = 1'b0;
                    s_nxt.valid = '0;
                end else if (stop_c) begin
                    s_nxt.sda_drive = 1'b0;
                    if (s_r.ph != PH_IDLE && s_r.idx == IDX_DATA && !s_r.rd && |s_r.valid) begin
                        s_nxt.ph = PH_PROG;
                        s_nxt.page = '0;
                        s_nxt.pos = '0;
                    end else begin
                        s_nxt.ph = PH_IDLE;
                    end
                end else begin
                    case (s_r.ph)
                        PH_RX: begin
                            if (scl_rise) begin
                                s_nxt.shreg = {s_r.shreg[BYTE_BITS-2:0], pins.sda};
                                s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                            end
                            if (scl_fall && s_r.bitcnt == BIT_LAST) begin
                                // ack is driven only after the clock has gone low
                                s_nxt.ph = PH_ACK;
                                s_nxt.sda_drive = 1'b1;
                                case (s_r.idx)
                                    IDX_CTRL: begin
                                        if (s_r.shreg[7:4] != DEV_TYPE ||
                                            s_r.shreg[3:1] != pins.cs) begin
                                            s_nxt.ph = PH_IGNORE;
                                            s_nxt.sda_drive = 1'b0;
                                        end
                                        s_nxt.rd = (s_r.shreg[0] != RW_WRITE);
                                        s_nxt.idx = IDX_ADDR_HI;
                                    end
                                    IDX_ADDR_HI: begin
                                        s_nxt.base_addr[ADDR_W-1:BYTE_BITS] =
                                            s_r.shreg[ADDR_HI_W-1:0];
                                        s_nxt.idx = IDX_ADDR_LO;
                                    end
                                    IDX_ADDR_LO: begin
                                        s_nxt.base_addr[BYTE_BITS-1:0] = s_r.shreg;
                                        s_nxt.addr_ptr = {s_r.base_addr[ADDR_W-1:BYTE_BITS],
                                                          s_r.shreg};
                                        s_nxt.wptr = {{(PTR_W-POS_W){1'b0}},
                                                      s_r.shreg[POS_W-1:0]};
                                        s_nxt.valid = '0;
                                        s_nxt.idx = IDX_DATA;
                                    end
                                    default: begin
                                        s_nxt.cache[s_r.wptr] = s_r.shreg;
                                        s_nxt.valid[s_r.wptr] = 1'b1;
                                        // six-bit pointer wraps into page 0 by itself
                                        s_nxt.wptr = s_r.wptr + PTR_W'(1);
                                        s_nxt.addr_ptr = s_r.addr_ptr + ADDR_W'(1);
                                    end
                                endcase
                            end
                        end
                        PH_ACK: begin
                            if (scl_fall) begin
                                s_nxt.sda_drive = 1'b0;
                                s_nxt.bitcnt = '0;
                                // read transfers are not served: stay off the bus
                                s_nxt.ph = s_r.rd ? PH_IGNORE : PH_RX;
                            end
                        end
                        PH_IGNORE: begin
                            s_nxt.sda_drive = 1'b0;
                        end
                        default: begin
                            s_nxt.sda_drive = 1'b0;
                        end
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= CTL_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // open drain: the pad only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe_n = ~s_r.sda_drive;
    assign arr_we = s_r.arr.we;
    assign arr_addr = s_r.arr.addr;
    assign arr_wdata = s_r.arr.data;
    assign busy = (s_r.ph == PH_PROG) || (s_r.ph == PH_WAIT);
    assign standby = (s_r.ph == PH_IDLE);
endmodule // serial_eeprom_write_cache

// File: tb.sv
// self-checking testbench for the serial eeprom write cache
`timescale 1ns/100ps
module tb
    import eeprom_cache_pkg::*;
();
    localparam int unsigned PC = 400;
    logic mclk;
    logic nrst;
    logic scl;
    logic sda_pull;
    logic sda_oe_n;
    logic sda_out;
    logic sda_bus;
    logic [CS_W-1:0] cs_pins;
    logic arr_we;
    logic [ADDR_W-1:0] arr_addr;
    logic [BYTE_BITS-1:0] arr_wdata;
    logic busy;
    logic standby;
    logic [BYTE_BITS-1:0] wmem [logic [ADDR_W-1:0]];
    int wcount;
    int bcnt;
    int failures;
    int cmp_count;
    // pull-up unless someone pulls low; an unknown enable stays unknown while the master releases the line
    assign sda_bus = !(sda_pull || !sda_oe_n);
    bus_master_model m (.mclk(mclk), .sda_bus(sda_bus), .scl(scl), .sda_pull(sda_pull));
    serial_eeprom_write_cache #(.PAGE_CYCLES(PC)) dut (
        .mclk(mclk), .nrst(nrst), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .chip_select_pins(cs_pins), .arr_we(arr_we),
        .arr_addr(arr_addr), .arr_wdata(arr_wdata), .busy(busy), .standby(standby)
    );
    initial begin
        mclk = 1'b0;
        forever #4 mclk = !mclk;
    end
    always @(posedge mclk) begin
        if (arr_we === 1'b1) begin
            wmem[arr_addr] = arr_wdata;
            wcount++;
        end
        if (busy === 1'b1)
            bcnt++;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic clear();
        wmem.delete();
        wcount = 0;
        bcnt = 0;
    endtask
    task automatic cmd(input logic [2:0] cs, input logic [12:0] a, input int n,
                       input logic [7:0] d0, input logic ok);
        logic ack;
        m.start();
        m.send({DEV_TYPE_DFLT, cs, RW_WRITE}, ack);
        check("ctrl ack", ack, ok);
        m.send({3'h0, a[12:8]}, ack);
        m.send(a[7:0], ack);
        for (int i = 0; i < n; i++) begin
            m.send(d0 + i[7:0], ack);
            check("data ack", ack, ok);
        end
        m.stop();
    endtask
    // returns how many polls were refused before the acknowledge
    task automatic poll(output int nacks);
        logic ack;
        nacks = 0;
        ack = 1'b0;
        while (!ack && nacks < 100) begin
            m.start();
            m.send({DEV_TYPE_DFLT, cs_pins, RW_WRITE}, ack);
            m.stop();
            if (!ack)
                nacks++;
        end
        check("poll ack", ack, 1);
    endtask
    task automatic t_single();
        int nacks;
        clear();
        cmd(cs_pins, 13'h0012, 1, 8'h5a, 1'b1);
        poll(nacks);
        check("busy nacks", nacks != 0, 1);
        check("writes", wcount, 1);
        check("byte", wmem[13'h0012], 8'h5a);
        check("pages", bcnt / PC, 1);
        check("standby", standby, 1);
        $display("single byte test done");
    endtask
    task automatic t_wrap();
        int nacks;
        int n;
        clear();
        cmd(cs_pins, 13'h001a, 66, 8'h40, 1'b1);
        poll(nacks);
        check("writes", wcount, 64);
        check("pages", bcnt / PC, 8);
        for (int s = 0; s < 64; s++) begin
            n = (s + 62) % 64 + ((s == 2 || s == 3) ? 64 : 0);
            check("slot", wmem[13'h0018 + s[12:0]], 8'h40 + n);
        end
        $display("wrap test done");
    endtask
    task automatic t_aligned();
        int nacks;
        clear();
        cmd(cs_pins, 13'h01f8, 16, 8'h80, 1'b1);
        poll(nacks);
        check("writes", wcount, 16);
        check("pages", bcnt / PC, 2);
        for (int i = 0; i < 16; i++)
            check("run byte", wmem[13'h01f8 + i[12:0]], 8'h80 + i);
        $display("aligned test done");
    endtask
    task automatic t_foreign();
        logic ack;
        clear();
        cmd(cs_pins ^ 3'h7, 13'h0030, 2, 8'h11, 1'b0);
        repeat (50) @(negedge mclk);
        check("foreign busy", busy, 0);
        check("writes", wcount, 0);
        m.start();
        m.send({DEV_TYPE_DFLT, cs_pins, 1'b1}, ack);
        m.stop();
        check("read ack", ack, 1);
        $display("select test done");
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        nrst = 1'b0;
        cs_pins = 3'h5;
        failures = 0;
        cmp_count = 0;
        clear();
        repeat (20) @(negedge mclk);
        nrst = 1'b1;
        repeat (125) @(negedge mclk);
        t_single();
        t_wrap();
        t_aligned();
        t_foreign();
        finish_test();
    end
    // the four tests need about 23000 cycles
    initial begin
        repeat (60000) @(posedge mclk);
        failures++;
        finish_test();
    end
endmodule // tb
